/* File: common/brkobj_map.svh */
// Register map, field positions, reset values and timing for the breaker
// object controller. Assumes a 20 MHz ref_clk and 32-bit APB.
`ifndef BRKOBJ_MAP_SVH
`define BRKOBJ_MAP_SVH

// Byte offsets on APB
`define BRKOBJ_CTRL_OFS      12'h000
`define BRKOBJ_TRAV_OFS      12'h004
`define BRKOBJ_CPUL_OFS      12'h008
`define BRKOBJ_OPUL_OFS      12'h00C
`define BRKOBJ_TERM_OFS      12'h010
`define BRKOBJ_FTP_OFS       12'h014
`define BRKOBJ_STAT_OFS      12'h018
`define BRKOBJ_OFAIL_OFS     12'h01C
`define BRKOBJ_CFAIL_OFS     12'h020
`define BRKOBJ_OOK_OFS       12'h024
`define BRKOBJ_COK_OFS       12'h028
`define BRKOBJ_CLR_OFS       12'h02C

// Control register fields
`define BRKOBJ_CTRL_TYPE_LSB 0
`define BRKOBJ_CTRL_SYNC_BIT 2
`define BRKOBJ_CTRL_RDY_LSB  3
`define BRKOBJ_CTRL_SRC_LSB  5
`define BRKOBJ_CTRL_RST      32'h0000_0039

// Timing: settings are in 20 ms steps, one tick is 20 ms
`define BRKOBJ_CLK_HZ        20000000
`define BRKOBJ_STEP_MS       20
`define BRKOBJ_TICK_CYC      ((`BRKOBJ_CLK_HZ / 1000) * `BRKOBJ_STEP_MS)
`define BRKOBJ_TRAV_RST      32'h0000_000A
`define BRKOBJ_PUL_RST       32'h0000_000A
`define BRKOBJ_TERM_RST      32'h0000_01F4
`define BRKOBJ_FTP_RST       32'h0000_000A
`define BRKOBJ_STEP_MAX      32'h0000_61A8

`endif

/* File: common/brkobj_pkg.sv */
// Types shared by the breaker object controller.
// Assumes the constants of brkobj_map.svh.
package brkobj_pkg;
  typedef enum logic [1:0] {
    BRKOBJ_WDCB = 2'h0, BRKOBJ_CB = 2'h1,
    BRKOBJ_DMC  = 2'h2, BRKOBJ_DGND = 2'h3
  } brkobj_type_t;
  typedef enum logic [1:0] {
    BRKOBJ_POS_MID = 2'h0, BRKOBJ_POS_OPEN = 2'h1,
    BRKOBJ_POS_CLOSED = 2'h2, BRKOBJ_POS_BAD = 2'h3
  } brkobj_pos_t;
  typedef enum logic [1:0] {
    BRKOBJ_IDLE = 2'h0, BRKOBJ_PULSE = 2'h1, BRKOBJ_WAIT = 2'h3
  } brkobj_state_t;
  // Status pins from the breaker mechanism
  typedef struct packed {
    logic open_st;
    logic close_st;
    logic cart_racked_in_input;
    logic cart_pulled_out_input;
    logic ready;
    logic sync_ok;
  } brkobj_sense_t;
  // Requests: local, remote, application; open and close each
  typedef struct packed {
    logic [2:0] open_req;
    logic [2:0] close_req;
  } brkobj_req_t;
  // Relay and event outputs
  typedef struct packed {
    logic open_cmd;
    logic close_cmd;
    logic final_trip;
    logic err_evt;
  } brkobj_act_t;
endpackage : brkobj_pkg

/* File: core/brkobj_cnt.sv */
// Saturating 32-bit request counter with synchronous clear.
// Assumes inc and clr come from logic on the same clock.
`timescale 1ns/10ps
module brkobj_cnt #(
  parameter int W = 32
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         clr,
  input  wire logic         inc,
  output logic [W-1:0]      cnt_r
);
  // Clear wins; count holds at all ones instead of wrapping
  always_ff @(posedge ref_clk) begin
    if (rst || clr) begin
      cnt_r <= '0;
    end else if (inc && !(&cnt_r)) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule : brkobj_cnt

/* File: core/brkobj_ctrl.sv */
// Breaker object control: position decode, open/close requests, relay
// pulses, termination timeout, final trip, request counters over APB.
// Assumes status and request pins are asynchronous and get synchronised.
//
// What this block does
// - Separate saturating failed open/close counters
// - Clear statistics zeroes all request counters
// - Clear selector returns idle after clearing
// - Earthing disconnector reports position only
// - Main disconnector: control without readiness or sync
// - Withdrawable type adds cart monitoring
// - Open input high means object open
// - Close input high means object closed
// - Cart inputs: high means in, or out
// - Both inputs beyond traverse time: bad
// - Close pulse limited, ends on state change
// - Open pulse limited, ends on state change
// - Termination timeout raises error, ends control
// - Final-trip pulse for set length, zero continuous
// - Final trip only when no reclose expected
// - Local, remote, application sources, each selectable
// - Open and close on separate relays
// - Neither active intermediate, both active bad
// - Sync enabled refuses close without permission
// - Readiness check with selectable polarity
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`include "brkobj_map.svh"
module brkobj_ctrl #(
  parameter int TICK_CYC = `BRKOBJ_TICK_CYC
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire brkobj_pkg::brkobj_sense_t sense,
  input  wire brkobj_pkg::brkobj_req_t   req,
  input  wire logic                  reclose_pending,
  output brkobj_pkg::brkobj_act_t    act,
  output brkobj_pkg::brkobj_pos_t    pos,
  output brkobj_pkg::brkobj_pos_t    cart_pos
);
  import brkobj_pkg::*;
  default clocking dflt_cb @(posedge ref_clk); endclocking
  default disable iff (rst); // Checks rest while in reset
  // Two-stage synchronisers for the pins
  brkobj_sense_t sense_m_r, sense_r;
  brkobj_req_t   req_m_r, req_r, req_d_r;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      {sense_m_r, sense_r, req_m_r, req_r, req_d_r} <= '0;
    end else begin
      sense_m_r <= sense;
      sense_r   <= sense_m_r;
      req_m_r   <= req;
      req_r     <= req_m_r;
      req_d_r   <= req_r;
    end
  end
  // Settings registers, in 20 ms ticks
  logic [31:0] ctrl_r, trav_r, cpul_r, opul_r, term_r, ftp_r;
  logic        clr_r;              // Clear selector, self-returning
  brkobj_type_t otype;
  assign otype = brkobj_type_t'(ctrl_r[`BRKOBJ_CTRL_TYPE_LSB +: 2]);

  // APB decode; zero-wait answers
  logic wr_en, rd_en;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  // Settings are clamped to the legal step range
  function automatic logic [31:0] clamp(input logic [31:0] v);
    clamp = (v > `BRKOBJ_STEP_MAX) ? `BRKOBJ_STEP_MAX : v;
  endfunction : clamp
  // Register writes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_r <= `BRKOBJ_CTRL_RST;
      trav_r <= `BRKOBJ_TRAV_RST;
      cpul_r <= `BRKOBJ_PUL_RST;
      opul_r <= `BRKOBJ_PUL_RST;
      term_r <= `BRKOBJ_TERM_RST;
      ftp_r  <= `BRKOBJ_FTP_RST;
    end else if (wr_en) begin
      case (paddr)
        `BRKOBJ_CTRL_OFS: ctrl_r <= pwdata & 32'h0000_00FF;
        `BRKOBJ_TRAV_OFS: trav_r <= clamp(pwdata);
        `BRKOBJ_CPUL_OFS: cpul_r <= clamp(pwdata);
        `BRKOBJ_OPUL_OFS: opul_r <= clamp(pwdata);
        `BRKOBJ_TERM_OFS: term_r <= clamp(pwdata);
        `BRKOBJ_FTP_OFS:  ftp_r  <= clamp(pwdata);
        default: ;
      endcase
    end
  end
  // Clear strobe: one cycle, then reads back idle by itself
  always_ff @(posedge ref_clk) begin
    clr_r <= !rst && wr_en && (paddr == `BRKOBJ_CLR_OFS) && pwdata[0];
  end
  // 20 ms tick generator; free-running, so each time is +-1 tick
  logic [31:0] pre_r;
  logic        tick;
  assign tick = (pre_r == 32'(TICK_CYC - 1));
  always_ff @(posedge ref_clk) begin
    pre_r <= (rst || tick) ? 32'h0 : pre_r + 32'h1;
  end
  // Position decode with traverse window
  logic        o_st, c_st, trans;
  logic [31:0] trav_cnt_r;
  assign o_st  = sense_r.open_st;
  assign c_st  = sense_r.close_st;
  assign trans = (o_st == c_st);
  always_ff @(posedge ref_clk) begin
    if (rst || !trans) begin
      trav_cnt_r <= '0;
    end else if (tick && trav_cnt_r < trav_r) begin
      trav_cnt_r <= trav_cnt_r + 32'h1;
    end
  end
  // Last settled position is held until the traverse time runs out
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pos <= BRKOBJ_POS_MID;
    end else if (!trans) begin
      pos <= o_st ? BRKOBJ_POS_OPEN : BRKOBJ_POS_CLOSED;
    end else if (trav_cnt_r >= trav_r) begin
      pos <= o_st ? BRKOBJ_POS_BAD : BRKOBJ_POS_MID;
    end
  end
  // Cart position only for withdrawable breakers
  always_ff @(posedge ref_clk) begin
    if (rst || otype != BRKOBJ_WDCB) begin
      cart_pos <= BRKOBJ_POS_MID;
    end else begin
      cart_pos <= brkobj_pos_t'({sense_r.cart_racked_in_input,
                                 sense_r.cart_pulled_out_input});
    end
  end
  // Request edges from enabled sources
  logic [2:0] src_en;
  logic       open_rq, close_rq, can_ctl, chk, close_ok;
  assign src_en   = ctrl_r[`BRKOBJ_CTRL_SRC_LSB +: 3];
  assign open_rq  = |(req_r.open_req & ~req_d_r.open_req & src_en);
  assign close_rq = |(req_r.close_req & ~req_d_r.close_req & src_en);
  assign can_ctl  = (otype != BRKOBJ_DGND);
  assign chk      = (otype == BRKOBJ_WDCB) || (otype == BRKOBJ_CB);
  // Readiness: field 0 off, 1 high, 2 low; sync by enable bit
  logic rdy_ok, sync_ok;
  always_comb begin
    case (ctrl_r[`BRKOBJ_CTRL_RDY_LSB +: 2])
      2'h1:    rdy_ok = sense_r.ready;
      2'h2:    rdy_ok = !sense_r.ready;
      default: rdy_ok = 1'b1;
    endcase
  end
  assign sync_ok  = !ctrl_r[`BRKOBJ_CTRL_SYNC_BIT] || sense_r.sync_ok;
  assign close_ok = !chk || (rdy_ok && sync_ok);
  // Command sequencer
  brkobj_state_t st_r;
  logic          is_close_r;
  logic [31:0]   pul_cnt_r, term_cnt_r;
  logic          reached, o_fail, c_fail, o_done, c_done;
  assign reached = is_close_r ? (pos == BRKOBJ_POS_CLOSED)
                              : (pos == BRKOBJ_POS_OPEN);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r       <= BRKOBJ_IDLE;
      is_close_r <= 1'b0;
      pul_cnt_r  <= '0;
      term_cnt_r <= '0;
    end else begin
      if (tick) begin
        pul_cnt_r  <= pul_cnt_r + 32'h1;
        term_cnt_r <= term_cnt_r + 32'h1;
      end
      case (st_r)
        BRKOBJ_IDLE: begin
          pul_cnt_r  <= '0;
          term_cnt_r <= '0;
          if (can_ctl && open_rq) begin
            st_r       <= BRKOBJ_PULSE; // Open takes priority
            is_close_r <= 1'b0;
          end else if (can_ctl && close_rq && close_ok) begin
            st_r       <= BRKOBJ_PULSE;
            is_close_r <= 1'b1;
          end
        end
        BRKOBJ_PULSE: begin
          if (reached) begin
            st_r <= BRKOBJ_IDLE;
          end else if (pul_cnt_r >= (is_close_r ? cpul_r : opul_r)) begin
            st_r <= BRKOBJ_WAIT;
          end
        end
        BRKOBJ_WAIT: begin
          if (reached || term_cnt_r >= term_r) begin
            st_r <= BRKOBJ_IDLE;
          end
        end
        default: st_r <= BRKOBJ_IDLE;
      endcase
    end
  end
  // Outcome strobes
  logic timeout;
  assign timeout = (st_r == BRKOBJ_WAIT) && !reached
                   && (term_cnt_r >= term_r);
  assign o_fail = (timeout && !is_close_r);
  assign c_fail = (timeout && is_close_r) ||
    ((st_r == BRKOBJ_IDLE) && can_ctl && !open_rq && close_rq
     && !close_ok);
  assign o_done = (st_r != BRKOBJ_IDLE) && reached && !is_close_r;
  assign c_done = (st_r != BRKOBJ_IDLE) && reached && is_close_r;
  // Relay outputs and error event, each from its own flip-flop
  logic open_cmd_r, close_cmd_r, err_evt_r;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      open_cmd_r  <= 1'b0;
      close_cmd_r <= 1'b0;
      err_evt_r   <= 1'b0;
    end else begin
      open_cmd_r  <= (st_r == BRKOBJ_PULSE) && !is_close_r
                     && !reached;
      close_cmd_r <= (st_r == BRKOBJ_PULSE) && is_close_r
                     && !reached;
      err_evt_r   <= timeout;
    end
  end
  // Final trip after a successful open with no reclose pending
  logic        ft_on_r;
  logic [31:0] ft_cnt_r;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ft_on_r  <= 1'b0;
      ft_cnt_r <= '0;
    end else if (o_done && !reclose_pending) begin
      ft_on_r  <= 1'b1;
      ft_cnt_r <= '0;
    end else if (ft_on_r && ftp_r != '0) begin
      if (tick) begin
        ft_cnt_r <= ft_cnt_r + 32'h1;
      end
      if (ft_cnt_r >= ftp_r) begin
        ft_on_r <= 1'b0; // Zero length keeps it on
      end
    end else if (c_done) begin
      ft_on_r <= 1'b0;
    end
  end
  assign act = {open_cmd_r, close_cmd_r, ft_on_r, err_evt_r}; // One driver
  // Request counters
  logic [31:0] ofail_c, cfail_c, ook_c, cok_c;
  brkobj_cnt #(.W(32)) u_ofail (.ref_clk(ref_clk), .rst(rst),
    .clr(clr_r), .inc(o_fail), .cnt_r(ofail_c));
  brkobj_cnt #(.W(32)) u_cfail (.ref_clk(ref_clk), .rst(rst),
    .clr(clr_r), .inc(c_fail), .cnt_r(cfail_c));
  brkobj_cnt #(.W(32)) u_ook (.ref_clk(ref_clk), .rst(rst),
    .clr(clr_r), .inc(o_done), .cnt_r(ook_c));
  brkobj_cnt #(.W(32)) u_cok (.ref_clk(ref_clk), .rst(rst),
    .clr(clr_r), .inc(c_done), .cnt_r(cok_c));
  // Read mux, registered
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata <= '0;
    end else if (rd_en && !penable) begin
      case (paddr)
        `BRKOBJ_CTRL_OFS:  prdata <= ctrl_r;
        `BRKOBJ_TRAV_OFS:  prdata <= trav_r;
        `BRKOBJ_CPUL_OFS:  prdata <= cpul_r;
        `BRKOBJ_OPUL_OFS:  prdata <= opul_r;
        `BRKOBJ_TERM_OFS:  prdata <= term_r;
        `BRKOBJ_FTP_OFS:   prdata <= ftp_r;
        `BRKOBJ_STAT_OFS:  prdata <= {24'h0, act.final_trip,
                                      st_r, cart_pos, pos, 1'b0};
        `BRKOBJ_OFAIL_OFS: prdata <= ofail_c;
        `BRKOBJ_CFAIL_OFS: prdata <= cfail_c;
        `BRKOBJ_OOK_OFS:   prdata <= ook_c;
        `BRKOBJ_COK_OFS:   prdata <= cok_c;
        default:           prdata <= 32'h0;
      endcase
    end
  end
  // Checks, on the default clock and idle in reset
  property p_no_both_relays;
    !(act.open_cmd && act.close_cmd);
  endproperty
  a_no_both_relays: assert property (p_no_both_relays)
    else $error("open and close relays both on");
  property p_gnd_no_ctl;
    (otype == BRKOBJ_DGND && st_r == BRKOBJ_IDLE) |=> st_r == BRKOBJ_IDLE;
  endproperty
  a_gnd_no_ctl: assert property (p_gnd_no_ctl)
    else $error("earthing disconnector started control");
  property p_clr_zero;
    clr_r |=> (ofail_c == 0 && cfail_c == 0 && !clr_r);
  endproperty
  a_clr_zero: assert property (p_clr_zero)
    else $error("clear did not zero counters");
  property p_sync_refuse;
    (st_r == BRKOBJ_IDLE && close_rq && !open_rq && chk
     && ctrl_r[`BRKOBJ_CTRL_SYNC_BIT] && !sense_r.sync_ok)
    |=> st_r == BRKOBJ_IDLE;
  endproperty
  a_sync_refuse: assert property (p_sync_refuse)
    else $error("close taken without sync permission");
  property p_err_ends;
    timeout |=> (st_r == BRKOBJ_IDLE && act.err_evt);
  endproperty
  a_err_ends: assert property (p_err_ends)
    else $error("timeout did not end control");
  property p_bad_pos;
    (o_st && c_st && trav_cnt_r >= trav_r) |=> pos == BRKOBJ_POS_BAD;
  endproperty
  a_bad_pos: assert property (p_bad_pos)
    else $error("bad position not flagged");
  property p_mid_pos;
    (!o_st && !c_st && trav_cnt_r >= trav_r) |=> pos == BRKOBJ_POS_MID;
  endproperty
  a_mid_pos: assert property (p_mid_pos)
    else $error("intermediate position not flagged");
  property p_pulse_stop;
    (st_r == BRKOBJ_PULSE && reached) |=> !act.open_cmd && !act.close_cmd;
  endproperty
  a_pulse_stop: assert property (p_pulse_stop)
    else $error("pulse not ended on state change");
endmodule : brkobj_ctrl

/* File: dv/brkobj_mech.sv */
// Behavioural breaker mechanism driving the status pins of the controller.
// Assumes one ref_clk domain; the bench picks the fault mode.
`timescale 1ns/10ps
module brkobj_mech #(
  parameter int TRAVEL = 8
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire brkobj_pkg::brkobj_act_t act,
  input  wire logic [1:0]            mode,
  input  wire logic                  ready_i,
  input  wire logic                  sync_i,
  input  wire logic                  cin,
  input  wire logic                  cout,
  output brkobj_pkg::brkobj_sense_t  sense
);
  import brkobj_pkg::*;
  logic closed_r;  // Settled contact position
  logic moving_r;  // Contacts in travel, neither pin active
  int   cnt_r;     // Remaining travel cycles
  // Mode 0 obeys relays, 1 is stuck, 2 shows both, 3 shows neither
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      closed_r <= 1'b0;
      moving_r <= 1'b0;
      cnt_r    <= 0;
    end else if (moving_r) begin
      if (cnt_r == 0) begin
        moving_r <= 1'b0;
        closed_r <= ~closed_r;
      end else begin
        cnt_r <= cnt_r - 1;
      end
    end else if (mode == 2'h0 && ((act.close_cmd && !closed_r) ||
                                  (act.open_cmd && closed_r))) begin
      moving_r <= 1'b1;
      cnt_r    <= TRAVEL;
    end
  end
  // Pins are active high levels
  always_comb begin
    sense.open_st  = (mode == 2'h2) || (mode != 2'h3 && !moving_r &&
                                        !closed_r);
    sense.close_st = (mode == 2'h2) || (mode != 2'h3 && !moving_r &&
                                        closed_r);
    sense.cart_racked_in_input  = cin;
    sense.cart_pulled_out_input = cout;
    sense.ready   = ready_i;
    sense.sync_ok = sync_i;
  end
endmodule : brkobj_mech

/* File: dv/tb.sv */
// Self-checking bench for the breaker object controller over APB.
// Assumes TICK_CYC of 4, so one setting step is 4 clock cycles.
`timescale 1ns/10ps
`include "brkobj_map.svh"
`define CHK(a,b) begin samples_checked++; if ((a) !== (b)) begin \
  fail_count++; $display("ERROR t=%0t got %0h exp %0h", $time, (a), (b)); \
  end end
module tb;
  import brkobj_pkg::*;
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [5:0]  req_v;          // Close bits 2:0, open bits 5:3
  logic        reclose_pending;
  logic [1:0]  mode;
  logic        ready_i, sync_i, cin, cout;
  brkobj_req_t   req_s;
  brkobj_sense_t sense;
  brkobj_act_t   act;
  brkobj_pos_t   pos, cart_pos;
  int fail_count, samples_checked, cyc;
  int n_o, n_c, n_f, n_e;      // High cycles seen in a watch window
  assign req_s = req_v;
  brkobj_ctrl #(.TICK_CYC(4)) uut (.ref_clk(ref_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sense(sense), .req(req_s), .reclose_pending(reclose_pending),
    .act(act), .pos(pos), .cart_pos(cart_pos));
  brkobj_mech mech (.ref_clk(ref_clk), .rst(rst), .act(act), .mode(mode),
    .ready_i(ready_i), .sync_i(sync_i), .cin(cin), .cout(cout),
    .sense(sense));
  // Clock at 20 MHz
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Verdict, reached from the main flow or the hang guard
  task tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  // Hang guard; the whole run needs well under this many cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish;
    end
  end
  // One APB transfer, held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
           output logic [31:0] rd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    `CHK(pslverr, 1'b0)
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] v;
    apb(1'b1, a, d, v);
  endtask : wr
  task rchk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] v;
    apb(1'b0, a, 32'h0000_0000, v);
    `CHK(v, e)
  endtask : rchk
  // Raise one request pin for 9 cycles and count outputs for n cycles
  task rq(input int b, input int n);
    n_o = 0;
    n_c = 0;
    n_f = 0;
    n_e = 0;
    req_v[b] <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(negedge ref_clk);
      n_o += act.open_cmd;
      n_c += act.close_cmd;
      n_f += act.final_trip;
      n_e += act.err_evt;
      @(posedge ref_clk);
      if (i == 8) req_v[b] <= 1'b0;
    end
  endtask : rq
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, req_v} = '0;
    {reclose_pending, mode, cin, cout} = '0;
    {ready_i, sync_i, rst} = 3'b111;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rchk(`BRKOBJ_CTRL_OFS, `BRKOBJ_CTRL_RST);
    rchk(`BRKOBJ_TRAV_OFS, `BRKOBJ_TRAV_RST);
    rchk(`BRKOBJ_CPUL_OFS, `BRKOBJ_PUL_RST);
    rchk(`BRKOBJ_TERM_OFS, `BRKOBJ_TERM_RST);
    rchk(`BRKOBJ_FTP_OFS, `BRKOBJ_FTP_RST);
    rchk(12'h030, 32'h0000_0000);
    `CHK(pos, BRKOBJ_POS_OPEN)
    wr(`BRKOBJ_TERM_OFS, 32'h0000_001E);
    wr(`BRKOBJ_CTRL_OFS, 32'h0000_00E1);
    rq(0, 200);                                  // Local close
    `CHK(n_c inside {[4:20]}, 1'b1)
    `CHK(n_o, 0)
    `CHK(pos, BRKOBJ_POS_CLOSED)
    rq(4, 200);                                  // Remote open
    `CHK(n_o inside {[4:20]}, 1'b1)
    `CHK(n_f inside {[36:48]}, 1'b1)
    rq(2, 200);                                  // Application close
    `CHK(n_c > 0, 1'b1)
    reclose_pending <= 1'b1;
    rq(5, 200);                                  // Application open
    `CHK(n_o > 0, 1'b1)
    `CHK(n_f, 0)
    reclose_pending <= 1'b0;
    rchk(`BRKOBJ_COK_OFS, 32'h0000_0002);
    rchk(`BRKOBJ_OOK_OFS, 32'h0000_0002);
    // Readiness: high required but pin low, then low polarity
    ready_i <= 1'b0;
    wr(`BRKOBJ_CTRL_OFS, 32'h0000_00E9);
    rq(0, 60);
    `CHK(n_c, 0)
    rchk(`BRKOBJ_CFAIL_OFS, 32'h0000_0001);
    wr(`BRKOBJ_CTRL_OFS, 32'h0000_00F1);
    rq(0, 200);
    `CHK(n_c > 0, 1'b1)
    rq(3, 200);
    // Synchrocheck gate
    wr(`BRKOBJ_CTRL_OFS, 32'h0000_00E5);
    sync_i <= 1'b0;
    rq(0, 60);
    `CHK(n_c, 0)
    rchk(`BRKOBJ_CFAIL_OFS, 32'h0000_0002);
    sync_i <= 1'b1;
    rq(0, 200);
    `CHK(n_c > 0, 1'b1)
    // Stuck mechanism: full pulse, then termination error
    mode <= 2'h1;
    rq(3, 200);
    `CHK(n_o inside {[36:48]}, 1'b1)
    `CHK(n_e, 1)
    rchk(`BRKOBJ_OFAIL_OFS, 32'h0000_0001);
    mode <= 2'h0;
    wr(`BRKOBJ_CLR_OFS, 32'h0000_0001);
    rchk(`BRKOBJ_OFAIL_OFS, 32'h0000_0000);
    rchk(`BRKOBJ_CFAIL_OFS, 32'h0000_0000);
    rchk(`BRKOBJ_COK_OFS, 32'h0000_0000);
    rchk(`BRKOBJ_CLR_OFS, 32'h0000_0000);
    // Main disconnector ignores sync; earthing type never moves
    wr(`BRKOBJ_CTRL_OFS, 32'h0000_00E6);
    wr(`BRKOBJ_FTP_OFS, 32'h0000_0000);
    rq(3, 200);
    `CHK(n_f inside {[160:195]}, 1'b1)
    sync_i <= 1'b0;
    rq(0, 200);
    `CHK(n_c > 0, 1'b1)
    `CHK(n_f < 40, 1'b1)
    wr(`BRKOBJ_CTRL_OFS, 32'h0000_00E3);
    cin <= 1'b1;
    rq(3, 60);
    `CHK(n_o, 0)
    `CHK(cart_pos, BRKOBJ_POS_MID)
    wr(`BRKOBJ_CTRL_OFS, 32'h0000_00E0);
    repeat (10) @(posedge ref_clk);
    `CHK(cart_pos, BRKOBJ_POS_CLOSED)
    cout <= 1'b1;
    repeat (10) @(posedge ref_clk);
    `CHK(cart_pos, BRKOBJ_POS_BAD)
    // Position faults judged against the 40-cycle traverse time
    mode <= 2'h2;
    repeat (20) @(posedge ref_clk);
    `CHK(pos !== BRKOBJ_POS_BAD, 1'b1)
    repeat (40) @(posedge ref_clk);
    `CHK(pos, BRKOBJ_POS_BAD)
    mode <= 2'h3;
    repeat (60) @(posedge ref_clk);
    `CHK(pos, BRKOBJ_POS_MID)
    tally_and_finish;
  end
endmodule : tb
